// [verilog/apdac_output.v]
// What this block does
// - resolution 8, 10 or 12 bits by option
// - sample top bit is sign, 1 negative
// - pwm by default, dac by option
// - 8-bit: top:mid, D7 sign, D6-D0 length
// - fixed output cycle rate in every mode
// - cycle end sets sample request flag
// - cycle end loads store into active register
// - unwritten sample reused next cycle
// - enable starts output; disabled pins low
// - halt clears enable, pins float
// - 10-bit: top 9-6, mid 5-2, bottom[3:2]
// - 12-bit: top 11-8, mid 7-4, bottom 3-0
// - magnitude 0-511 or 0-2047, sign apart
// - wake mode: halted pins held low, watched
// - wake pulses one clock after neg pin goes above threshold
// - irq taken next clock, enable cleared
// - request rate normal or doubled by option
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`default_nettype none

`include "apdac_map.vh"

module apdac_output #(
  parameter OPT_TEN_BIT     = 0,  // 10-bit samples
  parameter OPT_TWELVE_BIT  = 0,  // 12-bit samples, wins over ten
  parameter OPT_DAC         = 0,  // dac mode instead of pwm
  parameter OPT_DOUBLE_RATE = 0,  // doubled request rate
  parameter OPT_WAKE        = 0   // speaker wake detector fitted
) (
  input  wire        clk_sys,         // system clock, 10 MHz
  input  wire        rst,             // async reset, active high
  input  wire        psel,            // apb select
  input  wire        penable,         // apb access phase
  input  wire        pwrite,          // apb write
  input  wire [7:0]  paddr,           // apb byte address
  input  wire [31:0] pwdata,          // apb write data
  output wire        pready,          // apb ready
  output reg  [31:0] prdata,          // apb read data
  output wire        pslverr,         // apb error on unmapped
  input  wire        halt_exec,       // halt instruction executed
  input  wire        halt_release,    // other wake source or resume
  input  wire        reti_exec,       // return from interrupt
  input  wire        neg_above_th,    // comparator: neg pin above level
  output reg         irq_take,        // interrupt accepted, pulse
  output reg         wake_req,        // speaker wake signal
  output reg         halted,          // halt state
  output reg  [1:0]  wake_sens,       // comparator sensitivity
  output reg  [11:0] dac_value,       // dac code, sign at top
  output reg         speaker_pos_out, // positive pin level
  output reg         speaker_pos_oe_n,// positive pin drive, low drives
  output reg         speaker_neg_out, // negative pin level
  output reg         speaker_neg_oe_n // negative pin drive, low drives
);

  // build options folded into the two resolution flags
  localparam MODE12 = (OPT_TWELVE_BIT != 0);
  localparam MODE10 = (OPT_TEN_BIT != 0) && !MODE12;

  // register reset images, read bit by bit in the reset branches
  localparam [1:0] CTRL_RST = `APDAC_CTRL_RST;
  localparam [3:0] WAKE_RST = `APDAC_WAKE_RST;

  // bus decode
  wire       acc;
  wire       setup;
  wire       wr;
  wire [5:0] idx;
  reg        mapped;
  wire       wr_status;
  wire       wr_ctrl;
  wire       wr_wake;
  wire       nib_wr;
  wire [1:0] nib_sel;

  // control state
  reg        req_flag_r;
  reg        out_en_r;
  reg        irq_en_r;
  reg        wake_en_r;
  reg        wake_flag_r;
  reg        halted_r;

  // sample path
  wire [3:0] act_top;
  wire [3:0] act_mid;
  wire [3:0] act_bot;
  wire       frame_end;
  wire       load;
  wire       pwm_run;
  wire       pwm_pos;
  wire       pwm_neg;
  wire       sample_sign;
  wire [7:0] sample_mag8;
  wire [11:0] sample_code;
  wire       wake_now;

  // sample assembled to 12 bits, sign in bit 11, low bits zero in 8- and 10-bit modes
  function [11:0] assemble;
    input [3:0] top;
    input [3:0] mid;
    input [3:0] bot;
    begin
      if (MODE12) begin
        assemble = {top, mid, bot};
      end else if (MODE10) begin
        assemble = {top, mid, bot[3:2], 2'h0};
      end else begin
        assemble = {top, mid, 4'h0};
      end
    end
  endfunction

  // magnitude brought to at most 255 clocks so the pulse fits a 305-clock normal-rate frame;
  // wider modes lose their lowest bits of time resolution here
  function [7:0] scale_mag;
    input [11:0] code;
    begin
      if (MODE12) begin
        scale_mag = code[10:3];
      end else if (MODE10) begin
        scale_mag = code[10:3];
      end else begin
        scale_mag = {1'b0, code[10:4]};
      end
    end
  endfunction

  // apb: zero wait states, read data captured in the setup cycle
  assign setup   = psel && !penable;
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && mapped;
  assign idx     = paddr[7:2];
  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;

  // write strobes per register; an unmapped index never lands
  // because wr already carries the mapped term
  assign wr_status = wr && (idx == `APDAC_IDX_STATUS);
  assign wr_ctrl   = wr && (idx == `APDAC_IDX_CTRL);
  assign wr_wake   = wr && (idx == `APDAC_IDX_WAKE);
  assign nib_wr    = wr && (idx == `APDAC_IDX_LOWEST || idx == `APDAC_IDX_LOW ||
                     idx == `APDAC_IDX_HIGH);
  assign nib_sel   = (idx == `APDAC_IDX_HIGH) ? `APDAC_NIB_TOP :
                     ((idx == `APDAC_IDX_LOW) ? `APDAC_NIB_MID : `APDAC_NIB_BOT);

  // address decode
  always @* begin
    case (idx)
      `APDAC_IDX_STATUS: mapped = 1'b1;
      `APDAC_IDX_LOWEST: mapped = 1'b1;
      `APDAC_IDX_CTRL:   mapped = 1'b1;
      `APDAC_IDX_LOW:    mapped = 1'b1;
      `APDAC_IDX_HIGH:   mapped = 1'b1;
      `APDAC_IDX_WAKE:   mapped = 1'b1;
      default:           mapped = 1'b0;
    endcase
  end

  // read mux; data registers are write only and read zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      case (idx)
        `APDAC_IDX_STATUS: prdata <= {29'h0, req_flag_r, 2'h0};
        `APDAC_IDX_CTRL:   prdata <= {30'h0, irq_en_r, out_en_r};
        `APDAC_IDX_WAKE:   prdata <= {28'h0, wake_flag_r, wake_sens, wake_en_r};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // request flag: set at each frame end, cleared by writing 0;
  // a set in the same cycle as the clear wins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_flag_r <= 1'b0;
    end else if (frame_end) begin
      req_flag_r <= 1'b1;
    end else if (wr_status && !pwdata[`APDAC_ST_REQ_BIT]) begin
      req_flag_r <= 1'b0;
    end
  end

  // output enable: halt overrides any write in the same cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_en_r <= CTRL_RST[`APDAC_CT_EN_BIT];
    end else if (halt_exec) begin
      out_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      out_en_r <= pwdata[`APDAC_CT_EN_BIT];
    end
  end

  // global interrupt enable: cleared on entry, set again by return
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_en_r <= 1'b0;
    end else if (irq_take) begin
      irq_en_r <= 1'b0;
    end else if (reti_exec) begin
      irq_en_r <= 1'b1;
    end else if (wr_ctrl) begin
      irq_en_r <= pwdata[`APDAC_CT_IRQ_BIT];
    end
  end

  // accept one clock after enable and flag meet; the flag itself stays
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_take <= 1'b0;
    end else begin
      irq_take <= irq_en_r && req_flag_r && !irq_take;
    end
  end

  // wake control register
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_en_r <= WAKE_RST[`APDAC_WK_EN_BIT];
      wake_sens <= WAKE_RST[`APDAC_WK_SENS_HI:`APDAC_WK_SENS_LO];
    end else if (wr_wake) begin
      wake_en_r <= pwdata[`APDAC_WK_EN_BIT];
      wake_sens <= pwdata[`APDAC_WK_SENS_HI:`APDAC_WK_SENS_LO];
    end
  end

  // wake only matters while halted with the detector armed
  assign wake_now = (OPT_WAKE != 0) && wake_en_r && halted_r && neg_above_th;

  // sticky wake flag, set wins over a software clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_flag_r <= 1'b0;
    end else if (wake_now) begin
      wake_flag_r <= 1'b1;
    end else if (wr_wake && !pwdata[`APDAC_WK_FLAG_BIT]) begin
      wake_flag_r <= 1'b0;
    end
  end

  // halt state; the clock is assumed to keep running for the detector
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      halted_r <= 1'b0;
    end else if (halt_exec) begin
      halted_r <= 1'b1;
    end else if (wake_now || halt_release) begin
      halted_r <= 1'b0;
    end
  end

  // registered copies of the wake signal and halt state
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
      halted   <= 1'b0;
    end else begin
      wake_req <= wake_now;
      halted   <= halted_r;
    end
  end

  // the store follows writes; while stopped the active register
  // tracks it so output starts with the data written beforehand
  assign pwm_run = out_en_r && !halted_r;
  assign load    = frame_end || !pwm_run;

  apdac_hold u_hold (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wr_en   (nib_wr),
    .wr_sel  (nib_sel),
    .wr_nib  (pwdata[3:0]),
    .load    (load),
    .act_top (act_top),
    .act_mid (act_mid),
    .act_bot (act_bot)
  );

  // resolution fixed at build time
  assign sample_code = assemble(act_top, act_mid, act_bot);
  assign sample_sign = sample_code[11];
  assign sample_mag8 = scale_mag(sample_code);

  apdac_pwm u_pwm (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .run         (pwm_run),
    .double_rate (OPT_DOUBLE_RATE != 0),
    .sign        (sample_sign),
    .mag8        (sample_mag8),
    .frame_end   (frame_end),
    .pos_q       (pwm_pos),
    .neg_q       (pwm_neg)
  );

  // dac code follows the active sample in dac builds only
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dac_value <= 12'h000;
    end else if (OPT_DAC != 0) begin
      dac_value <= pwm_run ? sample_code : 12'h000;
    end else begin
      dac_value <= 12'h000;
    end
  end

  // pin drive: halted floats unless the detector holds both pins at
  // ground; stopped or dac builds drive both low
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      speaker_pos_out  <= 1'b0;
      speaker_neg_out  <= 1'b0;
      speaker_pos_oe_n <= 1'b0;
      speaker_neg_oe_n <= 1'b0;
    end else if (halted_r) begin
      speaker_pos_out  <= 1'b0;
      speaker_neg_out  <= 1'b0;
      speaker_pos_oe_n <= !((OPT_WAKE != 0) && wake_en_r);
      speaker_neg_oe_n <= !((OPT_WAKE != 0) && wake_en_r);
    end else if (!pwm_run || OPT_DAC != 0) begin
      speaker_pos_out  <= 1'b0;
      speaker_neg_out  <= 1'b0;
      speaker_pos_oe_n <= 1'b0;
      speaker_neg_oe_n <= 1'b0;
    end else begin
      speaker_pos_out  <= pwm_pos;
      speaker_neg_out  <= pwm_neg;
      speaker_pos_oe_n <= 1'b0;
      speaker_neg_oe_n <= 1'b0;
    end
  end

endmodule // apdac_output

`default_nettype wire

// [verilog/apdac_map.vh]
`ifndef APDAC_MAP_VH
`define APDAC_MAP_VH

// register indexes; the byte address on the bus is four times the index
`define APDAC_IDX_STATUS     6'h00
`define APDAC_IDX_LOWEST     6'h08
`define APDAC_IDX_CTRL       6'h09
`define APDAC_IDX_LOW        6'h0a
`define APDAC_IDX_HIGH       6'h0b
`define APDAC_IDX_WAKE       6'h12

// field positions
`define APDAC_ST_REQ_BIT     2
`define APDAC_CT_EN_BIT      0
`define APDAC_CT_IRQ_BIT     1
`define APDAC_WK_EN_BIT      0
`define APDAC_WK_SENS_LO     1
`define APDAC_WK_SENS_HI     2
`define APDAC_WK_FLAG_BIT    3

// reset values
`define APDAC_CTRL_RST       2'h0
`define APDAC_WAKE_RST       4'h0

// nibble selectors of the holding store
`define APDAC_NIB_BOT        2'h0
`define APDAC_NIB_MID        2'h1
`define APDAC_NIB_TOP        2'h2

// timing: system clock and request rates in hertz
`define APDAC_CLK_HZ         10000000
`define APDAC_REQ_HZ         32768
`define APDAC_REQ2_HZ        65536
`define APDAC_FRAME_CYC      (`APDAC_CLK_HZ / `APDAC_REQ_HZ)
`define APDAC_FRAME2_CYC     (`APDAC_CLK_HZ / `APDAC_REQ2_HZ)

`endif

// [verilog/apdac_hold.v]
`timescale 1ns/100ps
`default_nettype none

`include "apdac_map.vh"

// holding store and active conversion register, three nibbles each
module apdac_hold (
  input  wire       clk_sys,   // system clock
  input  wire       rst,       // async reset, active high
  input  wire       wr_en,     // nibble write strobe
  input  wire [1:0] wr_sel,    // which nibble
  input  wire [3:0] wr_nib,    // write data
  input  wire       load,      // copy store into active register
  output reg  [3:0] act_top,   // active top nibble
  output reg  [3:0] act_mid,   // active mid nibble
  output reg  [3:0] act_bot    // active bottom nibble
);

  reg [3:0] hold_r [0:2];

  // store written nibbles; unwritten ones keep old data
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_r[0] <= 4'h0;
      hold_r[1] <= 4'h0;
      hold_r[2] <= 4'h0;
    end else if (wr_en && wr_sel != 2'h3) begin
      hold_r[wr_sel] <= wr_nib;
    end
  end

  // a load takes the store as it stood before this edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_top <= 4'h0;
      act_mid <= 4'h0;
      act_bot <= 4'h0;
    end else if (load) begin
      act_top <= hold_r[`APDAC_NIB_TOP];
      act_mid <= hold_r[`APDAC_NIB_MID];
      act_bot <= hold_r[`APDAC_NIB_BOT];
    end
  end

endmodule // apdac_hold

`default_nettype wire

// [verilog/apdac_pwm.v]
`timescale 1ns/100ps
`default_nettype none

`include "apdac_map.vh"

// frame timer and differential pulse former
module apdac_pwm (
  input  wire       clk_sys,     // system clock
  input  wire       rst,         // async reset, active high
  input  wire       run,         // output enabled
  input  wire       double_rate, // halve the frame
  input  wire       sign,        // 1 = negative sample
  input  wire [7:0] mag8,        // pulse length in clocks
  output wire       frame_end,   // last cycle of a frame, pulse
  output reg        pos_q,       // positive leg
  output reg        neg_q        // negative leg
);

  localparam [31:0] F1      = `APDAC_FRAME_CYC;
  localparam [31:0] F2      = `APDAC_FRAME2_CYC;
  localparam [8:0]  F1_LAST = F1[8:0] - 9'h001;
  localparam [8:0]  F2_LAST = F2[8:0] - 9'h001;

  reg  [8:0] cnt_r;
  wire [8:0] last;
  wire       active;

  assign last      = double_rate ? F2_LAST : F1_LAST;
  assign frame_end = run && (cnt_r == last);
  assign active    = run && ({1'b0, mag8} > cnt_r);

  // frame counter restarts whenever output is stopped
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 9'h000;
    end else if (!run || frame_end) begin
      cnt_r <= 9'h000;
    end else begin
      cnt_r <= cnt_r + 9'h001;
    end
  end

  // only one leg pulses; the other stays low
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      pos_q <= active && !sign;
      neg_q <= active && sign;
    end
  end

endmodule // apdac_pwm

`default_nettype wire

// [verification/apdac_output_props.sv]
`timescale 1ns/100ps
`default_nettype none
// port-side checks of the audio output block
module apdac_output_props (
  input wire logic        clk_sys,         // clock
  input wire logic        rst,             // reset
  input wire logic        psel,            // select
  input wire logic        penable,         // access
  input wire logic        pwrite,          // write
  input wire logic [7:0]  paddr,           // address
  input wire logic [31:0] pwdata,          // write data
  input wire logic        halt_exec,       // halt
  input wire logic        neg_above_th,    // comparator
  input wire logic        irq_take,        // irq taken
  input wire logic        wake_req,        // wake
  input wire logic        halted,          // halt state
  input wire logic [1:0]  wake_sens,       // sensitivity
  input wire logic [11:0] dac_value,       // dac code
  input wire logic        speaker_pos_out, // pos leg
  input wire logic        speaker_neg_out  // neg leg
);
  logic [8:0] run_r;   // cycles a leg has stayed high
  logic [8:0] run_nxt;

  // run length of the current pulse, either leg
  assign run_nxt = (speaker_pos_out || speaker_neg_out) ? run_r + 9'h001 : 9'h000;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_r <= 9'h000;
    end else begin
      run_r <= run_nxt;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  legs_apart_a: assert property (!(speaker_pos_out && speaker_neg_out))
    else $error("both legs high");
  pulse_cap_a: assert property (run_r <= 9'h07f)
    else $error("pulse longer than 127");
  halt_entry_a: assert property (halt_exec && !halted |-> ##2 halted)
    else $error("halt not entered");
  halt_quiet_a: assert property (halted |-> !speaker_pos_out && !speaker_neg_out)
    else $error("legs active in halt");
  wake_follow_a: assert property (wake_req |-> $past(neg_above_th) && halted)
    else $error("wake signal off comparator");
  irq_once_a: assert property (irq_take |=> (!irq_take) [*2])
    else $error("irq taken again");
  sens_write_a: assert property (psel && penable && pwrite && paddr == 8'h48
    |=> wake_sens == $past(pwdata[2:1]))
    else $error("sensitivity not written");
  pwm_build_a: assert property (dac_value == 12'h000)
    else $error("dac code in pwm build");
endmodule // apdac_output_props

bind apdac_output apdac_output_props u_props (.clk_sys, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .halt_exec, .neg_above_th, .irq_take, .wake_req, .halted, .wake_sens,
  .dac_value, .speaker_pos_out, .speaker_neg_out);
`default_nettype wire

// [verification/apdac_speaker_model.sv]
`timescale 1ns/100ps
`default_nettype none
// speaker across both legs, wake comparator on the negative leg
module apdac_speaker_model (
  input  wire logic clk_sys,          // clock
  input  wire logic speaker_pos_out,  // pos level
  input  wire logic speaker_pos_oe_n, // pos drive, low drives
  input  wire logic speaker_neg_out,  // neg level
  input  wire logic speaker_neg_oe_n, // neg drive, low drives
  input  wire logic sound,            // sound on the cone
  output var  logic neg_above_th      // neg leg above wake level
);
  int   runs[$];   // ended pulses, 1000 added for the neg leg
  int   len_p = 0; // running pos pulse
  int   len_n = 0; // running neg pulse
  logic flip = 1'b0;

  // a released leg has no pull: read as noise, never a kind level
  always @(posedge clk_sys) begin
    flip <= ~flip;
  end

  // comparator
  always_comb begin
    neg_above_th = speaker_neg_oe_n ? flip : (speaker_neg_out | sound);
  end

  // log each pulse with its leg when it ends
  always @(posedge clk_sys) begin
    if (speaker_pos_out && !speaker_pos_oe_n) begin
      len_p <= len_p + 1;
    end else if (len_p != 0) begin
      runs.push_back(len_p);
      len_p <= 0;
    end
    if (speaker_neg_out && !speaker_neg_oe_n) begin
      len_n <= len_n + 1;
    end else if (len_n != 0) begin
      runs.push_back(1000 + len_n);
      len_n <= 0;
    end
  end
endmodule // apdac_speaker_model
`default_nettype wire

// [verification/audio_pwm_dac_output_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module audio_pwm_dac_output_bench;
  localparam int FRAME = 305; // 10 MHz clocks per 32768 Hz request
  logic        clk_sys, rst, psel, penable, pwrite, halt_exec, halt_release, reti_exec;
  logic        sound, pready, pslverr, irq_take, wake_req, halted, neg_above_th;
  logic        speaker_pos_out, speaker_pos_oe_n, speaker_neg_out, speaker_neg_oe_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  wake_sens;
  logic [11:0] dac_value;
  int          errors, total_checks, seed, m_store, m_act, t, last_t, w, n;
  int          cyc = 0;

  apdac_output #(.OPT_WAKE(1)) uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .halt_exec, .halt_release, .reti_exec,
    .neg_above_th, .irq_take, .wake_req, .halted, .wake_sens, .dac_value,
    .speaker_pos_out, .speaker_pos_oe_n, .speaker_neg_out, .speaker_neg_oe_n);
  apdac_speaker_model spk (.clk_sys, .speaker_pos_out, .speaker_pos_oe_n,
    .speaker_neg_out, .speaker_neg_oe_n, .sound, .neg_above_th);

  // clock, cycle count and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  initial begin
    repeat (10000) @(posedge clk_sys);
    errors++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; idle edge after it so strobes never toggle twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {28'h0, d}, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  // 8-bit sample: top nibble, mid nibble; bottom nibble unused in this build
  task automatic set_sample(input int s);
    wr(8'h2c, s[7:4]);
    wr(8'h28, s[3:0]);
    wr(8'h20, s[11:8]);
    m_store = s & 255;
  endtask

  function automatic int rnd();
    return ($random(seed) & 32'hfff) | 32'h10; // length kept at 16 or more
  endfunction

  task automatic wait_irq();
    n = 0;
    @(negedge clk_sys);
    while (irq_take !== 1'b1 && n < 2 * FRAME) begin
      @(negedge clk_sys);
      n++;
    end
    t = cyc;
    chk("irq", 32'h1, {31'h0, irq_take});
    @(posedge clk_sys);
  endtask

  initial begin
    seed = 79;
    errors = 0;
    total_checks = 0;
    {rst, psel, penable, pwrite, halt_exec, halt_release, reti_exec, sound} = 8'h80;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk(8'h24, 32'h0, 1'b0);
    rd_chk(8'h48, 32'h0, 1'b0);
    rd_chk(8'h00, 32'h0, 1'b0);
    rd_chk(8'h04, 32'h0, 1'b1);
    set_sample(rnd());
    rd_chk(8'h2c, 32'h0, 1'b0);
    wr(8'h24, 4'h3);
    m_act = m_store;
    // one pulse per frame, double buffered, flag and irq at each frame end
    for (int i = 0; i < 6; i++) begin
      wait_irq();
      if (i > 0) chk("frame", FRAME, t - last_t);
      last_t = t;
      rd_chk(8'h00, 32'h4, 1'b0);
      chk("pulses", 1, spk.runs.size());
      chk("pulse", (m_act >> 7) * 1000 + (m_act & 127), spk.runs.pop_front());
      m_act = m_store;
      if (i == 0) set_sample(8'h7f);
      else if (i == 1) set_sample(8'hff);
      else if (i != 3) set_sample(rnd());
      wr(8'h00, 4'h0);
      reti_exec <= 1'b1;
      @(posedge clk_sys);
      reti_exec <= 1'b0;
    end
    wr(8'h24, 4'h0);
    @(negedge clk_sys);
    chk("pins off", 32'h0, {speaker_pos_out, speaker_neg_out,
        speaker_pos_oe_n, speaker_neg_oe_n});
    // halt while playing, no wake armed: legs float
    @(posedge clk_sys);
    wr(8'h24, 4'h1);
    halt_exec <= 1'b1;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("float", 32'h7, {halted, speaker_pos_oe_n, speaker_neg_oe_n});
    @(posedge clk_sys);
    rd_chk(8'h24, 32'h0, 1'b0);
    halt_release <= 1'b1;
    @(posedge clk_sys);
    halt_release <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("halted", 32'h0, {31'h0, halted});
    // armed halt, silent beforehand, woken by sound
    @(posedge clk_sys);
    w = 1 | (($random(seed) & 3) << 1);
    wr(8'h48, w[3:0]);
    rd_chk(8'h48, w, 1'b0);
    chk("sens", w >> 1, {30'h0, wake_sens});
    repeat (20) @(posedge clk_sys);
    halt_exec <= 1'b1;
    halt_release <= 1'b0;
    @(posedge clk_sys);
    halt_exec <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("held low", 32'h10, {halted, speaker_pos_out, speaker_neg_out,
        speaker_pos_oe_n, speaker_neg_oe_n});
    @(posedge clk_sys);
    sound <= 1'b1;
    n = 0;
    while (wake_req !== 1'b1 && n < 10) begin
      @(negedge clk_sys);
      n++;
    end
    chk("wake", 32'h3, {30'h0, halted, wake_req});
    @(negedge clk_sys);
    chk("woken", 32'h0, {30'h0, halted, wake_req});
    @(posedge clk_sys);
    sound <= 1'b0;
    rd_chk(8'h48, w | 8, 1'b0);
    wr(8'h48, w[3:0] | 4'h8);
    rd_chk(8'h48, w | 8, 1'b0);
    wr(8'h48, w[3:0]);
    rd_chk(8'h48, w, 1'b0);
    give_verdict();
  end
endmodule // audio_pwm_dac_output_bench
`default_nettype wire
